// File: hdl/ecp_defines.vh
// Constants for the enhanced capture/compare/PWM unit.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH
// Register byte addresses (printed offset index times four)
`define ECP_IDX_DEADBAND 8'h97
`define ECP_ADDR_DEADBAND 12'h25c
`define ECP_ADDR_CONTROL 12'h000
`define ECP_ADDR_VALUE 12'h004
`define ECP_ADDR_FLAGS 12'h008
`define ECP_ADDR_TIMER1 12'h00c
`define ECP_ADDR_TIMER2 12'h010
`define ECP_ADDR_PORT 12'h014
`define ECP_ADDR_PINS 12'h018
// Control register fields
`define ECP_MODE_LSB 0
`define ECP_MODE_MSB 3
`define ECP_DIR_BIT 7
`define ECP_HALF_BIT 6
// Flag register: capture/compare flag position
`define ECP_FLAG_BIT 2
// Timer two control fields in the timer two word
`define ECP_T2ON_BIT 10
`define ECP_T2PS_LSB 8
// Reset values
`define ECP_CONTROL_RST 8'h00
`define ECP_DEADBAND_RST 8'h00
// Mode codes
`define ECP_M_OFF 4'h0
`define ECP_M_CAP_FALL 4'h4
`define ECP_M_CAP_RISE 4'h5
`define ECP_M_CAP_4 4'h6
`define ECP_M_CAP_16 4'h7
`define ECP_M_CMP_SET 4'h8
`define ECP_M_CMP_CLR 4'h9
`define ECP_M_CMP_IRQ 4'ha
`define ECP_M_CMP_TGL 4'h2
// Prescaler counts
`define ECP_PRE4_LAST 4'h3
`define ECP_PRE16_LAST 4'hf
// Early switch lead in timer two counts for prescale 00, 01, 1x
`define ECP_LEAD_00 8'h01
`define ECP_LEAD_01 8'h04
`define ECP_LEAD_1X 8'h10
`endif

// File: hdl/ecp_unit.v
// Enhanced capture/compare/PWM unit with an AHB-Lite register slave.
// Assumes the pin input is asynchronous and software programs port
// direction; timer one ticks each clock, timer two drives the PWM.
//
// The AHB-Lite interface to the registers was left to the implementer.
`include "ecp_defines.vh"
module ecp_unit (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Capture pin input and bridge outputs, enables low while driving
   input wire capture_compare_pin_in,
   output reg bridge_out_a,
   output reg bridge_out_b,
   output reg bridge_out_c,
   output reg bridge_out_d,
   output reg [3:0] bridge_oe_n,
   // Flag level for the interrupt controller
   output reg capcmp_interrupt_flag
);
   // Mode decode shared by several processes
   function is_capture;
      input [3:0] m;
      begin
         is_capture = (m[3:2] == 2'b01);
      end
   endfunction
   function is_compare;
      input [3:0] m;
      begin
         is_compare = (m[3:2] == 2'b10) || (m == `ECP_M_CMP_TGL);
      end
   endfunction
   function is_pwm;
      input [3:0] m;
      begin
         is_pwm = (m[3:2] == 2'b11);
      end
   endfunction

   reg [7:0] ctrl_ff;
   reg [7:0] deadband_count_ff;
   reg [15:0] value_ff;
   reg [15:0] timer_one_count_ff;
   reg [7:0] timer_two_count_ff;
   reg [7:0] period_ff;
   reg [7:0] duty_ff;
   reg [2:0] t2ctl_ff;
   reg [3:0] t2pre_ff;
   reg [7:0] port_latch_ff;
   reg [7:0] port_dir_ff;
   reg cmp_latch_ff;
   reg [3:0] pre_ff;
   reg [1:0] pin_sync_ff;
   reg pin_prev_ff;
   reg dir_ff;
   reg [7:0] db_ff;
   reg pwm_prev_ff;
   reg dp_sel_ff;
   reg dp_write_ff;
   reg [11:0] dp_addr_ff;
   wire [3:0] mode = ctrl_ff[`ECP_MODE_MSB:`ECP_MODE_LSB];
   wire pin_s = pin_sync_ff[1];
   // Driven pin level: compare latch or port latch, else the pin
   wire pin_level = port_dir_ff[3] ? pin_s
                  : (is_compare(mode) ? cmp_latch_ff : port_latch_ff[3]);
   wire rise = pin_level & ~pin_prev_ff;
   wire fall = ~pin_level & pin_prev_ff;
   wire wr = dp_sel_ff & dp_write_ff;
   wire wr_ctrl = wr && dp_addr_ff == `ECP_ADDR_CONTROL;
   wire wr_flag = wr && dp_addr_ff == `ECP_ADDR_FLAGS;
   wire pre_hit = (mode == `ECP_M_CAP_4) ? (pre_ff == `ECP_PRE4_LAST)
                : (pre_ff == `ECP_PRE16_LAST);
   reg cap_evt;
   // Capture event selection
   always @* begin
      cap_evt = 1'b0;
      case (mode)
         `ECP_M_CAP_FALL: cap_evt = fall;
         `ECP_M_CAP_RISE: cap_evt = rise;
         `ECP_M_CAP_4: cap_evt = rise & pre_hit;
         `ECP_M_CAP_16: cap_evt = rise & pre_hit;
         default: cap_evt = 1'b0;
      endcase
   end
   wire match = is_compare(mode) && value_ff == timer_one_count_ff;
   // PWM time base on timer two
   wire [7:0] lead = t2ctl_ff[1] ? `ECP_LEAD_1X
                   : (t2ctl_ff[0] ? `ECP_LEAD_01 : `ECP_LEAD_00);
   wire t2_tick = t2ctl_ff[2] && (t2ctl_ff[1] ? t2pre_ff == 4'hf
                : (t2ctl_ff[0] ? t2pre_ff[1:0] == 2'h3 : 1'b1));
   wire t2_wrap = t2_tick && timer_two_count_ff >= period_ff;
   wire pwm_raw = timer_two_count_ff < duty_ff;
   wire dir_new = ctrl_ff[`ECP_DIR_BIT];
   // Early switch window near end of period
   wire [8:0] left = {1'b0, period_ff} - {1'b0, timer_two_count_ff};
   wire early = (dir_new != dir_ff) && t2ctl_ff[2] &&
                ({1'b0, left[7:0]} < {1'b0, lead}) && ~left[8];

   // Synchroniser for the capture pin
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sync_ff <= 2'b00;
         pin_prev_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[0], capture_compare_pin_in};
         pin_prev_ff <= pin_level;
      end
   end

   // Capture, compare and prescaler logic on timer one
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_one_count_ff <= 16'h0000;
         value_ff <= 16'h0000;
         pre_ff <= 4'h0;
         cmp_latch_ff <= 1'b0;
         capcmp_interrupt_flag <= 1'b0;
      end else begin
         timer_one_count_ff <= timer_one_count_ff + 16'h0001;
         if (!is_capture(mode))
            pre_ff <= 4'h0;
         else if (rise && mode[1]) begin
            if (pre_hit)
               pre_ff <= 4'h0;
            else
               pre_ff <= pre_ff + 4'h1;
         end
         if (wr && dp_addr_ff == `ECP_ADDR_TIMER1)
            timer_one_count_ff <= hwdata[15:0];
         if (cap_evt)
            value_ff <= timer_one_count_ff;
         else if (wr && dp_addr_ff == `ECP_ADDR_VALUE)
            value_ff <= hwdata[15:0];
         if (wr_ctrl && hwdata[7:0] == 8'h00)
            cmp_latch_ff <= 1'b0;
         else if (wr_ctrl && hwdata[3:0] == `ECP_M_CMP_SET)
            cmp_latch_ff <= 1'b1;
         else if (wr_ctrl && hwdata[3:0] == `ECP_M_CMP_CLR)
            cmp_latch_ff <= 1'b0;
         else if (match) begin
            case (mode)
               `ECP_M_CMP_SET: cmp_latch_ff <= 1'b0;
               `ECP_M_CMP_CLR: cmp_latch_ff <= 1'b1;
               `ECP_M_CMP_TGL: cmp_latch_ff <= ~cmp_latch_ff;
               default: cmp_latch_ff <= cmp_latch_ff;
            endcase
         end
         // Hardware set wins over a software clear
         if (cap_evt || match)
            capcmp_interrupt_flag <= 1'b1;
         else if (wr_flag)
            capcmp_interrupt_flag <= hwdata[`ECP_FLAG_BIT];
      end
   end

   // Timer two, direction and deadband
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_two_count_ff <= 8'h00;
         t2pre_ff <= 4'h0;
         dir_ff <= 1'b0;
         db_ff <= 8'h00;
         pwm_prev_ff <= 1'b0;
      end else begin
         t2pre_ff <= t2ctl_ff[2] ? t2pre_ff + 4'h1 : 4'h0;
         if (wr && dp_addr_ff == `ECP_ADDR_TIMER2) begin
            timer_two_count_ff <= hwdata[7:0];
            t2pre_ff <= 4'h0;
         end else if (t2_wrap) begin
            timer_two_count_ff <= 8'h00;
            dir_ff <= dir_new;
         end else if (t2_tick)
            timer_two_count_ff <= timer_two_count_ff + 8'h01;
         pwm_prev_ff <= pwm_raw;
         if (pwm_raw != pwm_prev_ff)
            db_ff <= deadband_count_ff;
         else if (db_ff != 8'h00)
            db_ff <= db_ff - 8'h01;
      end
   end

   // Output drivers
   // Count starts on the raw transition, so the active side turns on
   // exactly deadband cycles after the other side has turned off
   wire db_done = (pwm_raw != pwm_prev_ff) ? (deadband_count_ff == 8'h00)
                : (db_ff <= 8'h01);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bridge_out_a <= 1'b0;
         bridge_out_b <= 1'b0;
         bridge_out_c <= 1'b0;
         bridge_out_d <= 1'b0;
         bridge_oe_n <= 4'hf;
      end else begin
         bridge_oe_n <= {port_dir_ff[7:5], port_dir_ff[3]};
         if (is_pwm(mode) && ctrl_ff[`ECP_HALF_BIT]) begin
            // Each side goes active only after the deadband
            bridge_out_a <= pwm_raw & (db_done | bridge_out_a);
            bridge_out_b <= ~pwm_raw & (db_done | bridge_out_b);
            bridge_out_c <= port_latch_ff[6];
            bridge_out_d <= port_latch_ff[7];
         end else if (is_pwm(mode)) begin
            bridge_out_a <= early ? dir_ff : ~dir_ff;
            bridge_out_c <= early ? ~dir_ff : dir_ff;
            bridge_out_d <= ~early & ~dir_ff & pwm_raw;
            bridge_out_b <= ~early & dir_ff & pwm_raw;
         end else begin
            bridge_out_a <= is_compare(mode) ? cmp_latch_ff : port_latch_ff[3];
            bridge_out_b <= port_latch_ff[5];
            bridge_out_c <= port_latch_ff[6];
            bridge_out_d <= port_latch_ff[7];
         end
      end
   end

   // AHB-Lite address phase capture and register writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_sel_ff <= 1'b0;
         dp_write_ff <= 1'b0;
         dp_addr_ff <= 12'h000;
         ctrl_ff <= `ECP_CONTROL_RST;
         deadband_count_ff <= `ECP_DEADBAND_RST;
         period_ff <= 8'hff;
         duty_ff <= 8'h00;
         t2ctl_ff <= 3'b000;
         port_latch_ff <= 8'h00;
         port_dir_ff <= 8'hff;
      end else begin
         if (hready) begin
            dp_sel_ff <= hsel & htrans[1];
            dp_write_ff <= hwrite;
            dp_addr_ff <= haddr[11:0];
         end
         if (wr) begin
            case (dp_addr_ff)
               `ECP_ADDR_CONTROL: ctrl_ff <= hwdata[7:0];
               `ECP_ADDR_DEADBAND: deadband_count_ff <= hwdata[7:0];
               `ECP_ADDR_TIMER2: begin
                  period_ff <= hwdata[23:16];
                  duty_ff <= hwdata[31:24];
                  t2ctl_ff <= hwdata[10:8];
               end
               `ECP_ADDR_PORT: begin
                  port_latch_ff <= hwdata[7:0];
                  port_dir_ff <= hwdata[15:8];
               end
               default: ;
            endcase
         end
      end
   end

   // Read data and response
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[11:0])
               `ECP_ADDR_CONTROL: hrdata <= {24'h0, ctrl_ff};
               `ECP_ADDR_DEADBAND: hrdata <= {24'h0, deadband_count_ff};
               `ECP_ADDR_VALUE: hrdata <= {16'h0, value_ff};
               `ECP_ADDR_FLAGS:
                  hrdata <= {29'h0, capcmp_interrupt_flag, 2'b00};
               `ECP_ADDR_TIMER1: hrdata <= {16'h0, timer_one_count_ff};
               `ECP_ADDR_TIMER2: hrdata <= {duty_ff, period_ff, 5'h00,
                                           t2ctl_ff, timer_two_count_ff};
               `ECP_ADDR_PORT: hrdata <= {16'h0, port_dir_ff, port_latch_ff};
               `ECP_ADDR_PINS: hrdata <= {27'h0, pin_s, bridge_out_d,
                                          bridge_out_c, bridge_out_b,
                                          bridge_out_a};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // ecp_unit

// File: tb/ecp_pin_source.sv
// Signal source that drives the capture pin of the unit.
// Assumes the caller starts each burst just after a rising edge.
module ecp_pin_source (
   // Clock
   input logic hclk,
   // Pin level into the unit
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int t = 0;
   int rise_t[$];
   // Cycle count at the timer one rate
   always @(posedge hclk) t <= t + 1;
   // Edges move only after a clock edge, held two cycles or more
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         repeat (w) @(posedge hclk);
         pin <= 1'b1;
         rise_t.push_back(t);
         repeat (w) @(posedge hclk);
         pin <= 1'b0;
      end
   endtask
   initial pin = 1'b0;
endmodule // ecp_pin_source

// File: tb/ecp_unit_properties.sv
// Port checker for the capture/compare/PWM unit.
// Assumes one clock domain and a zero wait state register slave.
`include "ecp_defines.vh"
module ecp_unit_properties (
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // Register bus
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [31:0] hwdata,
   input logic hready,
   input logic [31:0] hrdata,
   input logic hreadyout,
   input logic hresp,
   // Bridge pins and flag
   input logic bridge_out_a,
   input logic bridge_out_b,
   input logic bridge_out_c,
   input logic bridge_out_d,
   input logic [3:0] bridge_oe_n,
   input logic capcmp_interrupt_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_ff, wr_ff;
   logic [11:0] adr_ff, last_ff;
   logic [31:0] dat_ff;
   logic [2:0] since_ff;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Data phase tracking and age of the last stored write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         adr_ff <= 12'h0;
         last_ff <= 12'hfff;
         dat_ff <= 32'h0;
         since_ff <= 3'h7;
      end else begin
         rd_ff <= hsel & htrans[1] & hready & !hwrite;
         wr_ff <= hsel & htrans[1] & hready & hwrite;
         adr_ff <= haddr[11:0];
         if (wr_ff) begin
            since_ff <= 3'h0;
            last_ff <= adr_ff;
            dat_ff <= hwdata;
         end else if (since_ff != 3'h7) begin
            since_ff <= since_ff + 3'h1;
         end
      end
   end
   property p_ready; hreadyout; endproperty
   a_ready: assert property (p_ready)
      else $error("wait state inserted");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay)
      else $error("error response seen");
   property p_rd_idle; !rd_ff |-> hrdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside data phase");
   property p_sticky;
      $fell(capcmp_interrupt_flag) |->
         since_ff < 3'h3 && last_ff == `ECP_ADDR_FLAGS;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without software");
   property p_oe_cause;
      $changed(bridge_oe_n) |->
         since_ff < 3'h3 && last_ff == `ECP_ADDR_PORT;
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("enables moved without port write");
   property p_rst;
      $rose(hresetn) |-> bridge_oe_n == 4'hf && !capcmp_interrupt_flag
         && {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} == 4'h0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("pins not idle after reset");
   property p_a_c; !(bridge_out_a && bridge_out_c); endproperty
   a_a_c: assert property (p_a_c)
      else $error("outputs a and c both active");
   property p_b_d; !(bridge_out_b && bridge_out_d); endproperty
   a_b_d: assert property (p_b_d)
      else $error("outputs b and d both active");
   property p_clr;
      since_ff == 3'h0 && last_ff == `ECP_ADDR_CONTROL && dat_ff == 32'h0
         |-> ##[1:2] !bridge_out_a;
   endproperty
   a_clr: assert property (p_clr)
      else $error("compare latch not cleared");
endmodule // ecp_unit_properties
bind ecp_unit ecp_unit_properties chk_u (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .bridge_out_a, .bridge_out_b, .bridge_out_c, .bridge_out_d,
   .bridge_oe_n, .capcmp_interrupt_flag);

// File: tb/enhanced_capture_compare_pwm_bench.sv
// Self-checking bench for the capture/compare/PWM unit.
// Assumes a zero wait state slave and the pin source partner model.
`include "ecp_defines.vh"
module enhanced_capture_compare_pwm_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, smp;
   logic hreadyout, hresp, pin, oa, ob, oc, od, flag;
   logic [3:0] oe_n;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 63;
   // Clock and read data as seen at each edge
   always #5 hclk = ~hclk;
   always @(posedge hclk) smp <= hrdata;
   ecp_unit dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .capture_compare_pin_in(pin), .bridge_out_a(oa),
      .bridge_out_b(ob), .bridge_out_c(oc), .bridge_out_d(od),
      .bridge_oe_n(oe_n), .capcmp_interrupt_flag(flag));
   ecp_pin_source src_u (.hclk, .pin);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      #1 q = smp;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic test_done;
      $display("tests %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #300000;
      fail_count++;
      test_done;
   end
   initial begin
      logic [31:0] v1, v2;
      logic [15:0] cmp;
      logic [3:0] mode[4] = '{`ECP_M_CAP_FALL, `ECP_M_CAP_RISE,
         `ECP_M_CAP_4, `ECP_M_CAP_16};
      int div[4] = '{1, 1, 4, 16};
      logic [3:0] cm[4] = '{`ECP_M_CMP_SET, `ECP_M_CMP_CLR,
         `ECP_M_CMP_TGL, `ECP_M_CMP_IRQ};
      logic pre[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      logic post[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      logic [7:0] ctl[4] = '{8'h0c, 8'h8c, 8'h4c, 8'h4c};
      int db, na, nb, nc, nd;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset values, unmapped hole, deadband storage
      rd_chk(`ECP_ADDR_CONTROL, 32'h0);
      rd_chk(`ECP_ADDR_DEADBAND, 32'h0);
      rd_chk(12'h100, 32'h0);
      v1 = $random(seed) & 32'hff;
      wr(`ECP_ADDR_DEADBAND, v1);
      rd_chk(`ECP_ADDR_DEADBAND, v1);
      $display("registers test done");
      // Every capture event kind, prescaler edge counts
      wr(`ECP_ADDR_PORT, 32'hff00);
      for (int i = 0; i < 4; i++) begin
         wr(`ECP_ADDR_CONTROL, 32'h0);
         wr(`ECP_ADDR_CONTROL, {28'h0, mode[i]});
         wr(`ECP_ADDR_FLAGS, 32'h0);
         src_u.pulses(div[i] - 1, 3);
         wt(4);
         check(32'(flag), 32'h0);
         src_u.pulses(1, 3);
         wt(4);
         rd_chk(`ECP_ADDR_FLAGS, 32'h4);
      end
      check(32'(oe_n), 32'hf);
      $display("capture modes test done");
      // Third capture overwrites the unread second value
      wr(`ECP_ADDR_CONTROL, 32'h0);
      wr(`ECP_ADDR_CONTROL, {28'h0, `ECP_M_CAP_RISE});
      src_u.rise_t.delete();
      src_u.pulses(1, 2 + $unsigned($random(seed)) % 5);
      wt(4);
      bus(1'b0, `ECP_ADDR_VALUE, 32'h0, v1);
      src_u.pulses(2, 2 + $unsigned($random(seed)) % 5);
      wt(4);
      bus(1'b0, `ECP_ADDR_VALUE, 32'h0, v2);
      check(v2 - v1 & 32'hffff,
         (src_u.rise_t[2] - src_u.rise_t[0]) & 32'hffff);
      $display("overwrite test done");
      // Every compare action, presets and clearing of the latch
      wr(`ECP_ADDR_PORT, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`ECP_ADDR_CONTROL, 32'h0);
         wr(`ECP_ADDR_FLAGS, 32'h0);
         wt(2);
         check(32'(oa), 32'h0);
         wr(`ECP_ADDR_CONTROL, {28'h0, cm[i]});
         wt(3);
         check(32'(oa), 32'(pre[i]));
         cmp = $random(seed);
         wr(`ECP_ADDR_VALUE, {16'h0, cmp});
         wr(`ECP_ADDR_TIMER1, {16'h0, cmp - 16'd20});
         wt(30);
         check(32'(oa), 32'(post[i]));
         check(32'(flag), 32'h1);
      end
      check(32'(oe_n), 32'h0);
      wr(`ECP_ADDR_CONTROL, 32'h0);
      rd_chk(`ECP_ADDR_PORT, 32'h0);
      $display("compare test done");
      // Port write on an output pin, then software clear of the flag
      wr(`ECP_ADDR_CONTROL, {28'h0, `ECP_M_CAP_RISE});
      wr(`ECP_ADDR_FLAGS, 32'h0);
      wr(`ECP_ADDR_PORT, 32'h8);
      wt(5);
      check(32'(flag), 32'h1);
      wr(`ECP_ADDR_FLAGS, 32'h0);
      wt(1);
      check(32'(flag), 32'h0);
      $display("port write test done");
      // Bridge outputs over one 20 cycle period, duty 10, prescale 1:1
      wr(`ECP_ADDR_PORT, 32'h0);
      wr(`ECP_ADDR_TIMER2, 32'h0a130400);
      for (int i = 0; i < 4; i++) begin
         db = (i == 3) ? 1 + $unsigned($random(seed)) % 5 : 0;
         wr(`ECP_ADDR_DEADBAND, db);
         wr(`ECP_ADDR_CONTROL, {24'h0, ctl[i]});
         wt(45);
         na = 0;
         nb = 0;
         nc = 0;
         nd = 0;
         repeat (20) begin
            wt(1);
            na += oa;
            nb += ob;
            nc += oc;
            nd += od;
         end
         check(na, (i == 0) ? 20 : (i == 1) ? 0 : 10 - db);
         check(nb, (i == 1) ? 10 : (i == 0) ? 0 : 10 - db);
         check(nc, (i == 1) ? 20 : 0);
         check(nd, (i == 0) ? 10 : 0);
      end
      $display("bridge test done");
      test_done;
   end
endmodule // enhanced_capture_compare_pwm_bench
